//--- design/mec_pkg.sv
// Shared constants and types for the memory error capture block.
// Assumes a single 125 MHz clock domain and same-domain error sources.
package mec_pkg;
  // Widths of the captured fields.
  localparam int ADDR_W      = 32;
  localparam int DATA_W      = 32;
  localparam int SYN_W       = 7;
  localparam int REGION_W    = 4;
  localparam int PORT_W      = 3;
  localparam int LANE_W      = 4;
  localparam int CTRL_W      = 16;
  localparam int WORD_W      = 32;
  // Field positions.
  localparam int SYN_LSB        = 0;
  localparam int MREGION_LSB    = 0;
  localparam int CACHE_A_LSB    = 8;
  localparam int CACHE_B_LSB    = 12;
  localparam int PORT_LSB       = 10;
  localparam int LANE_LSB       = 0;
  localparam int NMI_BIT        = 14;
  localparam int PORT_EN_LSB    = 26;
  localparam int PORT_CODE_MAX  = 6;
  // Unit numbering: master, then bank a units, then bank b units.
  localparam int NUM_UNITS   = 5;
  localparam int NUM_CACHE   = 4;
  localparam int MASTER_IDX  = 0;
  localparam int BANK_A_CNT  = 2;
  // Reset values.
  localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;
  // Transfer timeout on the internal to native bus path.
  localparam int CLK_PERIOD_NS       = 8;
  localparam int XFER_TIMEOUT_NS     = 1000;
  localparam int XFER_TIMEOUT_CYCLES = (XFER_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MEC_KIND_NONE = 2'h0,
    MEC_KIND_ECC  = 2'h1,
    MEC_KIND_NXM  = 2'h3,
    MEC_KIND_AUX  = 2'h2
  } mec_kind_type;

  typedef enum logic [1:0] {
    MEC_TMO_IDLE = 2'h0,
    MEC_TMO_WAIT = 2'h1,
    MEC_TMO_HIT  = 2'h3
  } mec_tmo_type;
endpackage : mec_pkg

//--- design/mec_cap_if.sv
// Interface between the error block top and one capture unit.
// Assumes all signals live in the ref_clk domain.
`timescale 1ns/1ps
`default_nettype none
interface mec_cap_if;
  logic                              ecc_err;
  logic                              nxm_err;
  logic                              aux_err;
  logic                              ack;
  logic [mec_pkg::SYN_W-1:0]         syndrome;
  logic [mec_pkg::ADDR_W-1:0]        addr;
  logic [mec_pkg::DATA_W-1:0]        data;
  logic [mec_pkg::REGION_W-1:0]      region;
  logic                              valid;
  logic                              take;
  mec_pkg::mec_kind_type             kind;
  logic [mec_pkg::SYN_W-1:0]         cap_syndrome;
  logic [mec_pkg::ADDR_W-1:0]        cap_addr;
  logic [mec_pkg::DATA_W-1:0]        cap_data;
  logic [mec_pkg::REGION_W-1:0]      cap_region;

  modport unit (
    input  ecc_err, nxm_err, aux_err, ack, syndrome, addr, data, region,
    output valid, take, kind, cap_syndrome, cap_addr, cap_data, cap_region
  );
  modport owner (
    output ecc_err, nxm_err, aux_err, ack, syndrome, addr, data, region,
    input  valid, take, kind, cap_syndrome, cap_addr, cap_data, cap_region
  );
endinterface : mec_cap_if
`default_nettype wire

//--- design/mec_capture_unit.sv
// One error capture unit: syndrome, address, data and region latch.
// Assumes error strobes are one-cycle pulses from logic on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module mec_capture_unit (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Error sources and captured record
  mec_cap_if.unit   cap
);
  logic                          valid_ff;
  mec_pkg::mec_kind_type         kind_ff;
  logic [mec_pkg::SYN_W-1:0]     syn_ff;
  logic [mec_pkg::ADDR_W-1:0]    addr_ff;
  logic [mec_pkg::DATA_W-1:0]    data_ff;
  logic [mec_pkg::REGION_W-1:0]  region_ff;

  wire                           any_err   = cap.ecc_err | cap.nxm_err | cap.aux_err;
  // A new error in the ack cycle is captured rather than lost.
  wire                           take      = any_err & (~valid_ff | cap.ack); // see RULE16
  wire                           nxt_valid = take | (valid_ff & ~cap.ack);
  wire mec_pkg::mec_kind_type    nxt_kind  = cap.ecc_err ? mec_pkg::MEC_KIND_ECC :
                                             cap.nxm_err ? mec_pkg::MEC_KIND_NXM : mec_pkg::MEC_KIND_AUX;
  wire [mec_pkg::SYN_W-1:0]      nxt_syn   = cap.ecc_err ? cap.syndrome : '0; // see RULE1

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      valid_ff  <= 1'b0;
      kind_ff   <= mec_pkg::MEC_KIND_NONE;
      syn_ff    <= '0;
      addr_ff   <= '0;
      data_ff   <= '0;
      region_ff <= '0;
    end else begin
      valid_ff <= nxt_valid;
      if (take) begin // see RULE9
        kind_ff   <= nxt_kind;
        syn_ff    <= nxt_syn;
        addr_ff   <= cap.addr;
        data_ff   <= cap.data; // see RULE5
        region_ff <= cap.region;
      end
    end
  end

  assign cap.valid        = valid_ff;
  assign cap.take         = take;
  assign cap.kind         = kind_ff;
  assign cap.cap_syndrome = syn_ff;
  assign cap.cap_addr     = addr_ff;
  assign cap.cap_data     = data_ff;
  assign cap.cap_region   = region_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_syndrome_capture: assert property (cap.ecc_err && take |=> syn_ff == $past(cap.syndrome)) // see RULE1
    else $error("syndrome not captured on ecc error");
  a_data_capture: assert property (take |=> data_ff == $past(cap.data) && addr_ff == $past(cap.addr)) // see RULE5
    else $error("address or data not captured");
  a_record_held: assert property (valid_ff && !cap.ack |=> valid_ff && $stable(addr_ff) && $stable(data_ff)) // see RULE16
    else $error("captured record changed before firmware ack");
  a_error_flagged: assert property (any_err && !valid_ff |=> valid_ff) // see RULE9
    else $error("error not flagged");
  c_ack_and_error: cover property (cap.ack && any_err);
endmodule : mec_capture_unit
`default_nettype wire

//--- design/mec_memory_error_capture.sv
// Memory error capture top: master bridge unit plus four cache units.
// Assumes error sources, firmware strobes and config come from ref_clk logic.
//
// Operation
// RULE1 - On multi-bit ECC error store the 7-bit syndrome in ecc_syndrome_reg bits 0-6.
// RULE2 - Master captures faulting address and a 4-bit region code in master_region_reg.
// RULE3 - Bank a address combines cache error_address_reg with region_select_reg bits 8-11.
// RULE4 - Bank b address combines cache error_address_reg with region_select_reg bits 12-15.
// RULE5 - Every captured error latches the failing data word into error_data_reg.
// RULE6 - Master records an involved device port number in port_and_byte_ctrl bits 10-12.
// RULE7 - Reporting through the non-maskable interrupt sets diag_status_reg bit 14.
// RULE8 - Reporting through bridge_error_irq leaves diag_status_reg bit 14 clear.
// RULE9 - Master and every cache unit detect multi-bit ECC errors independently.
// RULE10 - Each cache unit owns syndrome, address and data registers apart from master.
// RULE11 - Master detects internal to native bus transfer timeout as an error.
// RULE12 - Master captures address, region and data of nonexistent memory accesses.
// RULE13 - Bank a units capture nonexistent memory accesses with region from region_select_reg.
// RULE14 - port_enable_word bits 26-31 map to device ports 1-6 for timeout checks.
// RULE15 - Write data parity error records the failing byte lane in port_and_byte_ctrl 0-3.
// RULE16 - Captured fields hold until firmware acknowledges; later transfers do not overwrite.
`timescale 1ns/1ps
`default_nettype none
module mec_memory_error_capture #(
  parameter int TIMEOUT_CYCLES = mec_pkg::XFER_TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic                                                ref_clk,
  input  wire logic                                                rst_n,
  // Master memory bridge unit error sources
  input  wire logic                                                m_ecc_err,
  input  wire logic                                                m_nxm_err,
  input  wire logic                                                m_wpar_err,
  input  wire logic [mec_pkg::SYN_W-1:0]                           m_syndrome,
  input  wire logic [mec_pkg::ADDR_W-1:0]                          m_addr,
  input  wire logic [mec_pkg::DATA_W-1:0]                          m_data,
  input  wire logic [mec_pkg::REGION_W-1:0]                        m_region,
  input  wire logic                                                m_port_valid,
  input  wire logic [mec_pkg::PORT_W-1:0]                          m_port,
  input  wire logic [mec_pkg::LANE_W-1:0]                          m_byte_lane,
  // Internal to native bus transfer tracking
  input  wire logic                                                xfer_start,
  input  wire logic                                                xfer_done,
  // Cache units: a0, a1, b0, b1
  input  wire logic [mec_pkg::NUM_CACHE-1:0]                       c_ecc_err,
  input  wire logic [mec_pkg::NUM_CACHE-1:0]                       c_nxm_err,
  input  wire logic [mec_pkg::NUM_CACHE-1:0][mec_pkg::SYN_W-1:0]   c_syndrome,
  input  wire logic [mec_pkg::NUM_CACHE-1:0][mec_pkg::ADDR_W-1:0]  c_addr,
  input  wire logic [mec_pkg::NUM_CACHE-1:0][mec_pkg::DATA_W-1:0]  c_data,
  // Configuration
  input  wire logic [mec_pkg::WORD_W-1:0]                          region_select_reg,
  input  wire logic [mec_pkg::WORD_W-1:0]                          port_enable_word,
  input  wire logic                                                nmi_select,
  // Firmware read acknowledge, one bit per unit
  input  wire logic [mec_pkg::NUM_UNITS-1:0]                       fw_ack,
  // Captured records
  output logic      [mec_pkg::NUM_UNITS-1:0]                       error_valid,
  output logic      [mec_pkg::NUM_UNITS-1:0][mec_pkg::SYN_W-1:0]   ecc_syndrome_reg,
  output logic      [mec_pkg::NUM_UNITS-1:0][mec_pkg::ADDR_W-1:0]  error_address_reg,
  output logic      [mec_pkg::NUM_UNITS-1:0][mec_pkg::DATA_W-1:0]  error_data_reg,
  output logic      [mec_pkg::NUM_UNITS-1:0][mec_pkg::REGION_W-1:0] error_region,
  output logic      [mec_pkg::REGION_W-1:0]                        master_region_reg,
  output logic      [mec_pkg::CTRL_W-1:0]                          port_and_byte_ctrl,
  output logic      [mec_pkg::CTRL_W-1:0]                          diag_status_reg,
  // Reporting
  output logic                                                     nmi_out,
  output logic                                                     bridge_error_irq,
  output logic                                                     timeout_err,
  output logic                                                     port_disabled_fault
);
  // Wide enough to hold TIMEOUT_CYCLES itself.
  localparam int CNT_W = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYCLES - 1);

  mec_cap_if cif [mec_pkg::NUM_UNITS] ();

  // Timeout tracker state.
  mec_pkg::mec_tmo_type  tmo_state_ff;
  mec_pkg::mec_tmo_type  nxt_tmo_state;
  logic [CNT_W-1:0]      tmo_cnt_ff;
  logic                  timeout_ff;

  // Master side records and reporting state.
  logic [mec_pkg::CTRL_W-1:0] ctrl_ff;
  logic [mec_pkg::CTRL_W-1:0] diag_ff;
  logic                       via_nmi_ff;
  logic                       nmi_ff;
  logic                       irq_ff;
  logic                       port_fault_ff;

  // Timeout detection on the internal to native bus path.
  // A start while waiting is ignored until done or expiry.
  wire tmo_expire = (tmo_state_ff == mec_pkg::MEC_TMO_WAIT) && !xfer_done && (tmo_cnt_ff == CNT_LAST);
  always_comb begin
    nxt_tmo_state = tmo_state_ff;
    case (tmo_state_ff)
      mec_pkg::MEC_TMO_IDLE: if (xfer_start) nxt_tmo_state = mec_pkg::MEC_TMO_WAIT;
      mec_pkg::MEC_TMO_WAIT: begin
        if (xfer_done) nxt_tmo_state = mec_pkg::MEC_TMO_IDLE;
        else if (tmo_expire) nxt_tmo_state = mec_pkg::MEC_TMO_HIT; // see RULE11
      end
      // Hit lasts one cycle, so a new start fits two cycles on.
      mec_pkg::MEC_TMO_HIT:  nxt_tmo_state = mec_pkg::MEC_TMO_IDLE;
      default:               nxt_tmo_state = mec_pkg::MEC_TMO_IDLE;
    endcase
  end
  // The count restarts at zero on each entry to wait.
  wire [CNT_W-1:0] nxt_tmo_cnt = (tmo_state_ff == mec_pkg::MEC_TMO_WAIT) ? tmo_cnt_ff + 1'b1 : '0;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tmo_state_ff <= mec_pkg::MEC_TMO_IDLE;
      tmo_cnt_ff   <= '0;
      timeout_ff   <= 1'b0;
    end else begin
      tmo_state_ff <= nxt_tmo_state;
      tmo_cnt_ff   <= nxt_tmo_cnt;
      timeout_ff   <= tmo_expire;
    end
  end

  // Master unit wiring; timeouts and write parity ride on the auxiliary strobe.
  // Hit is the single timeout strobe the master sees.
  wire tmo_event = (tmo_state_ff == mec_pkg::MEC_TMO_HIT);

  // Timeouts carry no syndrome, so zero is recorded.
  assign cif[mec_pkg::MASTER_IDX].ecc_err  = m_ecc_err;
  assign cif[mec_pkg::MASTER_IDX].nxm_err  = m_nxm_err; // see RULE12
  assign cif[mec_pkg::MASTER_IDX].aux_err  = tmo_event | m_wpar_err; // see RULE11
  assign cif[mec_pkg::MASTER_IDX].ack      = fw_ack[mec_pkg::MASTER_IDX];
  assign cif[mec_pkg::MASTER_IDX].syndrome = m_syndrome;
  assign cif[mec_pkg::MASTER_IDX].addr     = m_addr;
  assign cif[mec_pkg::MASTER_IDX].data     = m_data;
  assign cif[mec_pkg::MASTER_IDX].region   = m_region; // see RULE2

  // Same body as the cache units, fed by master strobes.
  mec_capture_unit u_master (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .cap     (cif[mec_pkg::MASTER_IDX])
  );

  // Cache units each own a separate record; region comes from the master select word.
  wire [mec_pkg::REGION_W-1:0] region_a = region_select_reg[mec_pkg::CACHE_A_LSB +: mec_pkg::REGION_W];
  wire [mec_pkg::REGION_W-1:0] region_b = region_select_reg[mec_pkg::CACHE_B_LSB +: mec_pkg::REGION_W];

  // Index 0 is the master, so cache unit gi sits at gi+1.
  genvar gi;
  generate
    for (gi = 0; gi < mec_pkg::NUM_CACHE; gi++) begin : g_cache
      assign cif[gi+1].ecc_err  = c_ecc_err[gi]; // see RULE9
      assign cif[gi+1].nxm_err  = c_nxm_err[gi]; // see RULE13
      assign cif[gi+1].aux_err  = 1'b0;
      assign cif[gi+1].ack      = fw_ack[gi+1];
      assign cif[gi+1].syndrome = c_syndrome[gi];
      assign cif[gi+1].addr     = c_addr[gi];
      assign cif[gi+1].data     = c_data[gi];
      // Bank a takes bits 8-11, bank b bits 12-15.
      assign cif[gi+1].region   = (gi < mec_pkg::BANK_A_CNT) ? region_a : region_b; // see RULE3 see RULE4

      mec_capture_unit u_cache (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .cap     (cif[gi+1])
      ); // see RULE10
    end

    // Records leave the units straight from their flip-flops.
    for (gi = 0; gi < mec_pkg::NUM_UNITS; gi++) begin : g_out
      assign error_valid[gi]       = cif[gi].valid;
      assign ecc_syndrome_reg[gi]  = cif[gi].cap_syndrome;
      assign error_address_reg[gi] = cif[gi].cap_addr;
      assign error_data_reg[gi]    = cif[gi].cap_data;
      assign error_region[gi]      = cif[gi].cap_region;
    end
  endgenerate

  // Master port and byte lane record follows the master capture, so it holds alongside it.
  // Bits outside the two fields keep their zero reset value.
  wire m_take     = cif[mec_pkg::MASTER_IDX].take;
  wire port_rec   = m_take && m_port_valid;
  wire lane_rec   = m_take && m_wpar_err && !m_ecc_err && !m_nxm_err;
  wire [mec_pkg::PORT_W-1:0] nxt_port = port_rec ? m_port : ctrl_ff[mec_pkg::PORT_LSB +: mec_pkg::PORT_W];
  wire [mec_pkg::LANE_W-1:0] nxt_lane = lane_rec ? m_byte_lane : ctrl_ff[mec_pkg::LANE_LSB +: mec_pkg::LANE_W];

  logic [mec_pkg::CTRL_W-1:0] nxt_ctrl;
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_ctrl[mec_pkg::PORT_LSB +: mec_pkg::PORT_W] = nxt_port; // see RULE6
    nxt_ctrl[mec_pkg::LANE_LSB +: mec_pkg::LANE_W] = nxt_lane; // see RULE15
  end

  // Port enable check for the port named in a timeout: bit 26 is port 1 up to bit 31 for port 6.
  // Codes 0 and 7 name no port and never raise the fault.
  wire [mec_pkg::PORT_CODE_MAX-1:0] port_en_field = port_enable_word[mec_pkg::PORT_EN_LSB +: mec_pkg::PORT_CODE_MAX];
  wire [mec_pkg::PORT_W-1:0]        port_idx      = m_port - 3'h1;
  wire port_in_range = (m_port != 3'h0) && (m_port <= 3'(mec_pkg::PORT_CODE_MAX));
  wire port_off      = port_in_range && !port_en_field[port_idx]; // see RULE14
  // The fault is only refreshed by a timeout capture that names a port.
  wire nxt_port_fault = (tmo_event && m_take && m_port_valid) ? port_off : port_fault_ff;

  // Reporting: the route is chosen whenever any unit takes an error and held until the next take.
  // Report lines drop in the same cycle as the last valid.
  logic [mec_pkg::NUM_UNITS-1:0] takes;
  logic [mec_pkg::NUM_UNITS-1:0] nxt_valids;
  generate
    for (gi = 0; gi < mec_pkg::NUM_UNITS; gi++) begin : g_rep
      assign takes[gi]      = cif[gi].take;
      assign nxt_valids[gi] = cif[gi].take | (cif[gi].valid & ~cif[gi].ack);
    end
  endgenerate

  wire any_take    = |takes;
  wire any_pending = |nxt_valids;
  wire nxt_via_nmi = any_take ? nmi_select : via_nmi_ff;

  // The route bit outlives the records so firmware can read it.
  logic [mec_pkg::CTRL_W-1:0] nxt_diag;
  always_comb begin
    nxt_diag = diag_ff;
    if (any_take) begin
      nxt_diag[mec_pkg::NMI_BIT] = nmi_select; // see RULE7 see RULE8
    end
  end

  // A take in the ack cycle keeps the route line high.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_ff       <= mec_pkg::CTRL_RST;
      diag_ff       <= mec_pkg::CTRL_RST;
      via_nmi_ff    <= 1'b0;
      nmi_ff        <= 1'b0;
      irq_ff        <= 1'b0;
      port_fault_ff <= 1'b0;
    end else begin
      ctrl_ff       <= nxt_ctrl;
      diag_ff       <= nxt_diag;
      via_nmi_ff    <= nxt_via_nmi;
      nmi_ff        <= any_pending && nxt_via_nmi;
      irq_ff        <= any_pending && !nxt_via_nmi;
      port_fault_ff <= nxt_port_fault;
    end
  end

  // Every output is a flip-flop, here or in a capture unit.
  assign master_region_reg   = cif[mec_pkg::MASTER_IDX].cap_region; // see RULE2
  assign port_and_byte_ctrl  = ctrl_ff;
  assign diag_status_reg     = diag_ff;
  assign nmi_out             = nmi_ff;
  assign bridge_error_irq    = irq_ff;
  assign timeout_err         = timeout_ff;
  assign port_disabled_fault = port_fault_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_nmi_route_flag: assert property (any_take && nmi_select |=> diag_ff[mec_pkg::NMI_BIT] && nmi_ff) // see RULE7
    else $error("nmi report without diag bit 14 set");

  a_irq_route_flag: assert property (any_take && !nmi_select |=> !diag_ff[mec_pkg::NMI_BIT] && irq_ff && !nmi_ff) // see RULE8
    else $error("irq report with diag bit 14 set");

  a_port_recorded: assert property (port_rec |=> ctrl_ff[12:10] == $past(m_port)) // see RULE6
    else $error("device port not recorded");

  a_lane_recorded: assert property (lane_rec |=> ctrl_ff[3:0] == $past(m_byte_lane)) // see RULE15
    else $error("byte lane not recorded");

  a_tmo_detect: assert property (tmo_expire |=> timeout_ff ##1 cif[0].valid) // see RULE11
    else $error("transfer timeout not reported");

  a_tmo_cancel: assert property (xfer_done && tmo_state_ff == mec_pkg::MEC_TMO_WAIT // see RULE11
    |=> !timeout_ff && !tmo_event) else $error("transfer done did not cancel the timeout");

  a_region_bank_a: assert property (cif[1].take |=> cif[1].cap_region == $past(region_select_reg[11:8])) // see RULE3
    else $error("bank a region not taken from bits 8-11");

  a_region_bank_b: assert property (cif[3].take |=> cif[3].cap_region == $past(region_select_reg[15:12])) // see RULE4
    else $error("bank b region not taken from bits 12-15");

  a_master_region: assert property (cif[0].take |=> master_region_reg == $past(m_region)) // see RULE2
    else $error("master region code not captured");

  a_cache_isolated: assert property (c_ecc_err[0] && !cif[0].valid && !m_ecc_err && !m_nxm_err // see RULE10
    && !cif[0].aux_err |=> !cif[0].valid) else $error("cache error reached the master record");

  a_port_enable_chk: assert property (tmo_event && m_take && m_port_valid |=> port_fault_ff == $past(port_off)) // see RULE14
    else $error("port enable check wrong");

  a_nxm_capture: assert property (m_nxm_err && !cif[0].valid |=> error_data_reg[0] == $past(m_data)) // see RULE12
    else $error("nonexistent memory data not captured");

  a_cache_nxm: assert property (c_nxm_err[0] && !cif[1].valid |=> error_address_reg[1] == $past(c_addr[0])) // see RULE13
    else $error("bank a nonexistent memory address not captured");

  c_timeout_seen: cover property (tmo_expire);

  c_cache_b_ecc: cover property (c_ecc_err[3] && !cif[4].valid);

  c_nmi_report: cover property (any_take && nmi_select);

  c_wpar_lane: cover property (lane_rec);
endmodule : mec_memory_error_capture
`default_nettype wire

//--- verification/mec_fw_model.sv
// Firmware model that reads each pending error record and acknowledges it.
// Assumes error_valid comes from the capture block on ref_clk; lag sets the reply delay.
`timescale 1ns/1ps
`default_nettype none
module mec_fw_model (
  // Clock
  input  wire logic                              ref_clk,
  // Control from the bench
  input  wire logic                              fw_en,
  input  wire logic [31:0]                       lag,
  // Capture block side
  input  wire logic [mec_pkg::NUM_UNITS-1:0]     error_valid,
  output var  logic [mec_pkg::NUM_UNITS-1:0]     fw_ack
);
  logic [mec_pkg::NUM_UNITS-1:0] ack_next;
  int cnt = 0;
  // One acknowledge per record; a record that stays after it is not acked twice.
  always @(posedge ref_clk) begin
    #1;
    ack_next = '0;
    if (!fw_en || error_valid == '0) cnt = 0;
    else if (cnt == lag) begin
      ack_next = error_valid;
      cnt = cnt + 1;
    end
    else if (cnt < lag) cnt = cnt + 1;
    fw_ack = ack_next;
  end
endmodule : mec_fw_model
`default_nettype wire

//--- verification/test_memory_error_capture.sv
// Self-checking bench for the memory error capture block.
// Assumes a 125 MHz ref_clk and a firmware model that acknowledges records.
`timescale 1ns/1ps
`default_nettype none
module test_memory_error_capture;
  localparam int TMO = 8;
  logic ref_clk = 1'b0, rst_n = 1'b0, fw_en = 1'b0;
  logic m_ecc_err, m_nxm_err, m_wpar_err, m_port_valid, xfer_start, xfer_done, nmi_select;
  logic [6:0] m_syndrome;
  logic [31:0] m_addr, m_data, region_select_reg, port_enable_word;
  logic [3:0] m_region, m_byte_lane, c_ecc_err, c_nxm_err;
  logic [2:0] m_port;
  logic [3:0][6:0] c_syndrome;
  logic [3:0][31:0] c_addr, c_data;
  logic [4:0] fw_ack, error_valid;
  logic [4:0][6:0] ecc_syndrome_reg;
  logic [4:0][31:0] error_address_reg, error_data_reg;
  logic [4:0][3:0] error_region;
  logic [3:0] master_region_reg;
  logic [15:0] port_and_byte_ctrl, diag_status_reg;
  logic nmi_out, bridge_error_irq, timeout_err, port_disabled_fault;
  int lag = 0, err_total = 0, checks_done = 0, cyc = 0;

  mec_memory_error_capture #(.TIMEOUT_CYCLES(TMO)) dut (.*);
  mec_fw_model fw (.ref_clk(ref_clk), .fw_en(fw_en), .lag(lag), .error_valid(error_valid), .fw_ack(fw_ack));

  always #4 ref_clk = ~ref_clk;
  // Cuts a hang short well beyond the few dozen cycles the scenarios need.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic tick; @(posedge ref_clk); #1; endtask : tick
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic finish_test;
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  // Lets the firmware model acknowledge everything, then checks that reports drop.
  task automatic drain(input int lg);
    lag = lg;
    fw_en = 1'b1;
    for (int k = 0; k < 20 && error_valid !== '0; k++) tick();
    chk("valid", error_valid, 32'h0);
    chk("nmi irq", {nmi_out, bridge_error_irq}, 32'h0);
    fw_en = 1'b0;
  endtask : drain

  task automatic t_master_ecc;
    nmi_select = 1'b1; m_syndrome = 7'h5B; m_addr = 32'h1234ABCD; m_data = 32'hCAFE0001;
    m_region = 4'h9; m_port_valid = 1'b1; m_port = 3'h3; m_ecc_err = 1'b1;
    tick();
    m_ecc_err = 1'b0; m_addr = 32'h0; m_data = 32'h0;
    chk("syn", ecc_syndrome_reg[0], 32'h5B);
    chk("addr", error_address_reg[0], 32'h1234ABCD);
    chk("region", master_region_reg, 32'h9);
    chk("data", error_data_reg[0], 32'hCAFE0001);
    chk("port", port_and_byte_ctrl[12:10], 32'h3);
    chk("diag14", diag_status_reg[14], 32'h1);
    chk("nmi irq", {nmi_out, bridge_error_irq}, 32'h2);
    m_syndrome = 7'h01; m_ecc_err = 1'b1;
    tick();
    m_ecc_err = 1'b0;
    tick();
    chk("held syn", ecc_syndrome_reg[0], 32'h5B);
    chk("held data", error_data_reg[0], 32'hCAFE0001);
    drain(3);
  endtask : t_master_ecc

  task automatic t_cache_ecc;
    nmi_select = 1'b0; region_select_reg = 32'h00005A00;
    for (int i = 0; i < 4; i++) begin
      c_syndrome[i] = 7'h10 + 7'(i); c_addr[i] = 32'hA0000000 + 32'(i); c_data[i] = 32'h5000000F - 32'(i);
    end
    c_ecc_err = 4'hF;
    tick();
    c_ecc_err = 4'h0;
    region_select_reg = 32'h0;
    for (int i = 0; i < 4; i++) begin
      chk("c syn", ecc_syndrome_reg[i+1], 32'h10 + i);
      chk("c addr", error_address_reg[i+1], 32'hA0000000 + i);
      chk("c data", error_data_reg[i+1], 32'h5000000F - i);
      chk("c region", error_region[i+1], (i < 2) ? 32'hA : 32'h5);
    end
    chk("master free", error_valid[0], 32'h0);
    chk("diag14", diag_status_reg[14], 32'h0);
    chk("nmi irq", {nmi_out, bridge_error_irq}, 32'h1);
    drain(0);
  endtask : t_cache_ecc

  task automatic t_nxm;
    nmi_select = 1'b1; region_select_reg = 32'h00000C00; m_addr = 32'h0BAD0000; m_data = 32'h0000FEED;
    m_region = 4'h6; c_addr[0] = 32'h00D00D00; c_data[0] = 32'h77777777;
    m_nxm_err = 1'b1; c_nxm_err = 4'h1;
    tick();
    m_nxm_err = 1'b0; c_nxm_err = 4'h0;
    chk("m nxm", {ecc_syndrome_reg[0], master_region_reg}, 32'h6);
    chk("m nxm addr", error_address_reg[0], 32'h0BAD0000);
    chk("m nxm data", error_data_reg[0], 32'h0000FEED);
    chk("a nxm addr", error_address_reg[1], 32'h00D00D00);
    chk("a nxm data", error_data_reg[1], 32'h77777777);
    chk("a nxm region", error_region[1], 32'hC);
    drain(1);
  endtask : t_nxm

  task automatic t_timeout;
    port_enable_word = 32'hF7FFFFFF; m_port_valid = 1'b1; m_port = 3'h2; m_addr = 32'h00C0FFEE;
    xfer_start = 1'b1;
    tick();
    xfer_start = 1'b0;
    // Start is taken at the first edge, so expiry shows TMO edges after it.
    repeat (TMO - 1) tick();
    chk("tmo early", timeout_err, 32'h0);
    tick();
    chk("tmo", timeout_err, 32'h1);
    tick();
    chk("tmo pulse", timeout_err, 32'h0);
    chk("tmo cap", error_address_reg[0], 32'h00C0FFEE);
    chk("port", port_and_byte_ctrl[12:10], 32'h2);
    chk("port off", port_disabled_fault, 32'h1);
    drain(2);
    xfer_start = 1'b1;
    tick();
    xfer_start = 1'b0;
    repeat (3) tick();
    xfer_done = 1'b1;
    tick();
    xfer_done = 1'b0;
    repeat (TMO + 2) tick();
    chk("done cancels", error_valid[0], 32'h0);
  endtask : t_timeout

  task automatic t_parity;
    nmi_select = 1'b0; m_port_valid = 1'b0; m_byte_lane = 4'h5; m_wpar_err = 1'b1;
    tick();
    m_wpar_err = 1'b0;
    chk("lane", port_and_byte_ctrl[3:0], 32'h5);
    chk("diag14", diag_status_reg[14], 32'h0);
    drain(0);
  endtask : t_parity

  initial begin
    {m_ecc_err, m_nxm_err, m_wpar_err, m_port_valid, xfer_start, xfer_done, nmi_select} = '0;
    {m_syndrome, m_addr, m_data, m_region, m_byte_lane, m_port} = '0;
    {c_ecc_err, c_nxm_err, c_syndrome, c_addr, c_data} = '0;
    region_select_reg = 32'h0;
    port_enable_word = 32'hFFFFFFFF;
    repeat (6) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    chk("rst valid", error_valid, 32'h0);
    chk("rst ctrl", port_and_byte_ctrl, 32'h0);
    t_master_ecc();
    t_cache_ecc();
    t_nxm();
    t_timeout();
    t_parity();
    finish_test();
  end
endmodule : test_memory_error_capture
`default_nettype wire
